// ===== shared/spi_port_pkg.sv
package spi_port_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [3:0] CTRL0_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] DATA_OFFSET = 4'h8;

  // ==========================================================
  // reset values
  localparam logic [7:0] CTRL0_RESET = 8'hE0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ==========================================================
  // module mode field encodings
  localparam logic [2:0] MODE_DIV4 = 3'h0;
  localparam logic [2:0] MODE_DIV16 = 3'h1;
  localparam logic [2:0] MODE_DIV64 = 3'h2;
  localparam logic [2:0] MODE_SUB = 3'h3;
  localparam logic [2:0] MODE_TIMER = 3'h4;
  localparam logic [2:0] MODE_SLAVE = 3'h5;

  // ==========================================================
  // timing counts: last count of each half serial clock period, bit and edge counts per word, synchronizer width
  localparam logic [4:0] DIV4_HALF_LAST = 5'h01;
  localparam logic [4:0] DIV16_HALF_LAST = 5'h07;
  localparam logic [4:0] DIV64_HALF_LAST = 5'h1F;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BITS_PER_WORD = 4'h8;
  localparam logic [4:0] LAST_EDGE = 5'h0F;
  localparam int SYNC_WIDTH = 4;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_MASTER = 3'h2,
    ST_SLAVE = 3'h4
  } xferState_t;

  typedef struct packed {
    logic [2:0] mode;
    logic uartSelect;
    logic [1:0] debounce;
    logic enable;
    logic incomplete;
  } ctrlZero_t;

  typedef struct packed {
    logic [1:0] spare;
    logic clockIdlePolarity;
    logic captureEdgeSelect;
    logic bitOrderSelect;
    logic selectPinEnable;
    logic writeCollision;
    logic transferComplete;
  } linkStatus_t;

  typedef struct packed {
    logic subClock;
    logic slaveSelectN;
    logic sdi;
    logic sck;
  } spiPinIn_t;

  typedef struct packed {
    logic sckOut;
    logic sckOe;
    logic sdoOut;
    logic sdoOe;
  } spiPinOut_t;

endpackage

// ===== hdl/spi_pin_sync.sv
`timescale 1ns/1ps
module spi_pin_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pins
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] firstQ;

  // ==========================================================
  // two flip-flops per pin
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock) begin
      if (rst) begin
        firstQ[i] <= 1'b1;
        syncOut[i] <= 1'b1;
      end else begin
        firstQ[i] <= asyncIn[i];
        syncOut[i] <= firstQ[i];
      end
    end
  end

endmodule

// ===== hdl/spi_clock_gen.sv
`timescale 1ns/1ps
module spi_clock_gen (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [2:0] mode,
  input wire logic subClock,
  input wire logic timerMatch,
  // half period tick
  output logic halfTick
);
  import spi_port_pkg::*;

  logic [4:0] divCountQ;
  logic [4:0] halfLast;
  logic subPrevQ;
  logic subEdge;

  // ==========================================================
  // rate select
  always_comb begin
    case (mode)
      MODE_DIV16: halfLast = DIV16_HALF_LAST;
      MODE_DIV64: halfLast = DIV64_HALF_LAST;
      default: halfLast = DIV4_HALF_LAST;
    endcase
  end

  // held at zero while run is low: counts only during a master transfer
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      divCountQ <= 5'h00;
    end else if (divCountQ == halfLast) begin
      divCountQ <= 5'h00;
    end else begin
      divCountQ <= divCountQ + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      subPrevQ <= 1'b1;
    end else begin
      subPrevQ <= subClock;
    end
  end

  assign subEdge = subClock ^ subPrevQ;

  // ==========================================================
  // one tick per half serial clock period
  always_comb begin
    case (mode)
      MODE_DIV4, MODE_DIV16, MODE_DIV64:
        halfTick = run && (divCountQ == halfLast);
      MODE_SUB: halfTick = run && subEdge;
      MODE_TIMER: halfTick = run && timerMatch;
      default: halfTick = 1'b0;
    endcase
  end

endmodule

// ===== hdl/spi_master_slave_port.sv
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module spi_master_slave_port (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm register slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // serial pins and clock sources
  input wire spi_port_pkg::spiPinIn_t pinIn,
  output spi_port_pkg::spiPinOut_t pinOut,
  input wire logic timerMatch,
  // interrupt request
  output logic irqRequest
);
  import spi_port_pkg::*;

  ctrlZero_t ctrlZeroQ;
  linkStatus_t statusQ;
  spiPinIn_t pinSync;
  xferState_t stateQ;
  logic [7:0] dataQ;
  logic [7:0] txQ;
  logic [7:0] rxQ;
  logic [7:0] rxNext;
  logic [4:0] edgeCountQ;
  logic [3:0] bitCountQ;
  logic respQ;
  logic sckLevelQ;
  logic sckPrevQ;
  logic busReq;
  logic writeLane;
  logic wrCtrl0;
  logic wrStatus;
  logic wrData;
  logic active;
  logic isMaster;
  logic isSlave;
  logic slaveSelected;
  logic halfTick;
  logic sckSeen;
  logic riseEdge;
  logic fallEdge;
  logic captureRising;
  logic captureEdge;
  logic edgeValid;
  logic capture;
  logic shiftOut;
  logic startMaster;
  logic startSlave;
  logic collision;
  logic masterDone;
  logic slaveDone;
  logic abortSlave;
  logic txHead;

  // ==========================================================
  // leaf blocks
  spi_pin_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
    .clock(clock),
    .rst(rst),
    .asyncIn(pinIn),
    .syncOut(pinSync)
  );

  spi_clock_gen u_clock_gen (
    .clock(clock),
    .rst(rst),
    .run(stateQ == ST_MASTER),
    .mode(ctrlZeroQ.mode),
    .subClock(pinSync.subClock),
    .timerMatch(timerMatch),
    .halfTick(halfTick)
  );

  // ==========================================================
  // avalon-mm slave: every access answers on its second cycle
  assign busReq = read | write;
  assign waitrequest = busReq & ~respQ;
  assign writeLane = write & respQ & byteenable[0];
  assign wrCtrl0 = writeLane && (address == CTRL0_OFFSET);
  assign wrStatus = writeLane && (address == STATUS_OFFSET);
  assign wrData = writeLane && (address == DATA_OFFSET);

  always_ff @(posedge clock) begin
    if (rst) begin
      respQ <= 1'b0;
    end else begin
      respQ <= busReq & ~respQ;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && !respQ) begin
      case (address)
        CTRL0_OFFSET: readdata <= {24'h00_0000, ctrlZeroQ};
        STATUS_OFFSET: readdata <= {24'h00_0000, statusQ};
        DATA_OFFSET: readdata <= {24'h00_0000, dataQ};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // role decode
  assign active = ctrlZeroQ.enable && !ctrlZeroQ.uartSelect &&
                  (ctrlZeroQ.mode <= MODE_SLAVE);
  assign isMaster = active && (ctrlZeroQ.mode != MODE_SLAVE);
  assign isSlave = active && (ctrlZeroQ.mode == MODE_SLAVE);
  assign slaveSelected = !statusQ.selectPinEnable ||
                         !pinSync.slaveSelectN;

  // ==========================================================
  // serial clock edges
  always_ff @(posedge clock) begin
    if (rst) begin
      sckLevelQ <= 1'b1;
    end else if (stateQ != ST_MASTER) begin
      sckLevelQ <= !statusQ.clockIdlePolarity;
    end else if (halfTick) begin
      sckLevelQ <= !sckLevelQ;
    end
  end

  assign sckSeen = isMaster ? sckLevelQ : pinSync.sck;

  always_ff @(posedge clock) begin
    if (rst) begin
      sckPrevQ <= 1'b1;
    end else begin
      sckPrevQ <= sckSeen;
    end
  end

  assign riseEdge = sckSeen & ~sckPrevQ;
  assign fallEdge = ~sckSeen & sckPrevQ;
  assign captureRising = ~(statusQ.clockIdlePolarity ^
                           statusQ.captureEdgeSelect);
  assign captureEdge = captureRising ? riseEdge : fallEdge;
  assign edgeValid = (stateQ == ST_MASTER) ||
                     (stateQ != ST_MASTER && isSlave &&
                      slaveSelected);
  assign capture = edgeValid & captureEdge;
  // output moves on the opposite edge, never before the first capture
  assign shiftOut = edgeValid && (riseEdge || fallEdge) &&
                    !captureEdge && (bitCountQ != 4'h0);

  // ==========================================================
  // transfer control
  assign collision = wrData && (stateQ != ST_IDLE);
  assign startMaster = wrData && isMaster &&
                       (stateQ == ST_IDLE);
  assign startSlave = (stateQ == ST_IDLE) && isSlave && slaveSelected &&
                      (riseEdge || fallEdge);
  assign masterDone = (stateQ == ST_MASTER) && (riseEdge || fallEdge) &&
                      (edgeCountQ == LAST_EDGE);
  assign slaveDone = (stateQ == ST_SLAVE) && capture &&
                     (bitCountQ == LAST_BIT);
  assign abortSlave = (stateQ == ST_SLAVE) && statusQ.selectPinEnable &&
                      pinSync.slaveSelectN;

  always_ff @(posedge clock) begin
    if (rst) begin
      stateQ <= ST_IDLE;
    end else begin
      case (stateQ)
        ST_IDLE: begin
          if (startMaster) begin
            stateQ <= ST_MASTER;
          end else if (startSlave) begin
            stateQ <= ST_SLAVE;
          end
        end
        ST_MASTER: begin
          if (!isMaster || masterDone) begin
            stateQ <= ST_IDLE;
          end
        end
        ST_SLAVE: begin
          if (!isSlave || slaveDone || abortSlave) begin
            stateQ <= ST_IDLE;
          end
        end
        default: stateQ <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst || startMaster || masterDone || slaveDone || abortSlave ||
        !active) begin
      bitCountQ <= 4'h0;
    end else if (capture) begin
      bitCountQ <= bitCountQ + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || startMaster || masterDone || !isMaster) begin
      edgeCountQ <= 5'h00;
    end else if ((stateQ == ST_MASTER) && (riseEdge || fallEdge)) begin
      edgeCountQ <= edgeCountQ + 5'h01;
    end
  end

  // ==========================================================
  // shift paths
  assign rxNext = statusQ.bitOrderSelect ? {rxQ[6:0], pinSync.sdi} :
                  {pinSync.sdi, rxQ[7:1]};
  assign txHead = statusQ.bitOrderSelect ? txQ[7] : txQ[0];

  always_ff @(posedge clock) begin
    if (rst) begin
      rxQ <= DATA_RESET;
    end else if (capture) begin
      rxQ <= rxNext;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      txQ <= DATA_RESET;
    end else if (startMaster) begin
      txQ <= writedata[7:0];
    end else if (stateQ == ST_IDLE) begin
      txQ <= dataQ;
    end else if (shiftOut) begin
      txQ <= statusQ.bitOrderSelect ? {txQ[6:0], 1'b0} :
             {1'b0, txQ[7:1]};
    end
  end

  // received word replaces the data register only after bit eight
  always_ff @(posedge clock) begin
    if (rst) begin
      dataQ <= DATA_RESET;
    end else if (wrData && stateQ == ST_IDLE) begin
      dataQ <= writedata[7:0];
    end else if (capture && bitCountQ == LAST_BIT) begin
      dataQ <= rxNext;
    end
  end

  // ==========================================================
  // control and status registers; hardware set wins over clear
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrlZeroQ <= CTRL0_RESET;
    end else begin
      if (wrCtrl0) begin
        ctrlZeroQ <= writedata[7:0];
      end
      if (abortSlave) begin
        ctrlZeroQ.incomplete <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      statusQ <= STATUS_RESET;
    end else begin
      if (wrStatus) begin
        statusQ.spare <= writedata[7:6];
        statusQ.clockIdlePolarity <= writedata[5];
        statusQ.captureEdgeSelect <= writedata[4];
        statusQ.bitOrderSelect <= writedata[3];
        statusQ.selectPinEnable <= writedata[2];
        if (!writedata[1]) begin
          statusQ.writeCollision <= 1'b0;
        end
        if (!writedata[0]) begin
          statusQ.transferComplete <= 1'b0;
        end
      end
      if (collision) begin
        statusQ.writeCollision <= 1'b1;
      end
      if (masterDone || slaveDone || abortSlave) begin
        statusQ.transferComplete <= 1'b1;
      end
    end
  end

  assign irqRequest = statusQ.transferComplete;

  // ==========================================================
  // pin drivers; input lines are never driven
  always_ff @(posedge clock) begin
    if (rst) begin
      pinOut <= '0;
    end else begin
      pinOut.sckOe <= isMaster;
      pinOut.sckOut <= sckLevelQ;
      pinOut.sdoOe <= isMaster || (isSlave && slaveSelected);
      pinOut.sdoOut <= (stateQ != ST_IDLE || (isSlave && slaveSelected)) ?
                       txHead : 1'b1;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_idle_clock_level: assert property (
    (isMaster && stateQ == ST_IDLE)[*3] |->
      pinOut.sckOe && pinOut.sckOut == !$past(statusQ.clockIdlePolarity, 2))
    else $error("idle serial clock at wrong level");

  a_release_when_off: assert property (
    (!ctrlZeroQ.enable)[*2] |-> !pinOut.sckOe && !pinOut.sdoOe)
    else $error("disabled port still drives a line");

  a_collision_sets: assert property (
    collision |=> statusQ.writeCollision)
    else $error("write during transfer did not flag collision");

  a_collision_sticky: assert property (
    statusQ.writeCollision && !(wrStatus && !writedata[1]) |=>
      statusQ.writeCollision)
    else $error("collision flag dropped without software clear");

  a_complete_flag: assert property (
    (masterDone || slaveDone) |=> statusQ.transferComplete && irqRequest)
    else $error("transfer end did not raise complete flag");

  a_write_starts: assert property (
    startMaster |=> stateQ == ST_MASTER && txQ == $past(writedata[7:0]))
    else $error("master data write did not start transfer");

  a_eight_bits: assert property (
    masterDone |-> bitCountQ + 4'(capture) == BITS_PER_WORD)
    else $error("master transfer did not move eight bits");

  a_sdo_idle_high: assert property (
    (isMaster && stateQ == ST_IDLE)[*2] |-> pinOut.sdoOe && pinOut.sdoOut)
    else $error("idle data output not driven high");

  a_word_held: assert property (
    stateQ != ST_IDLE && !capture |=> $stable(dataQ))
    else $error("data register changed mid transfer");

  a_spare_bits: assert property (
    wrStatus |=> statusQ.spare == $past(writedata[7:6]))
    else $error("spare bits did not store written value");

  a_incomplete: assert property (
    abortSlave |=> ctrlZeroQ.incomplete && statusQ.transferComplete &&
      stateQ == ST_IDLE)
    else $error("early deselect not flagged as incomplete");

  a_slave_ignores: assert property (
    isSlave && statusQ.selectPinEnable && pinSync.slaveSelectN &&
      stateQ != ST_MASTER |=> $stable(rxQ))
    else $error("deselected slave shifted data");

endmodule

// ===== verif/spi_far_end.sv
`timescale 1ns/1ps
// ==========================================================
// far end: slave to a master port, or master to a slave port
module spi_far_end (
  // clock
  input wire logic clock,
  // settings shared with the port
  input wire logic pol,
  input wire logic edgeSel,
  input wire logic msbFirst,
  // serial lines
  input wire logic sckLine,
  input wire logic sdoLine,
  output logic sdi,
  output logic sck,
  output logic slaveSelectN
);
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  logic prevSck = 1'b1;
  logic lastSdi = 1'b0;
  int cnt = 8;
  wire capRise = (pol == edgeSel);
  wire rise = sckLine & ~prevSck;
  wire fall = ~sckLine & prevSck;
  wire head = msbFirst ? tx[7] : tx[0];
  // outside a word the line shows the inverse of its last bit
  assign sdi = (cnt < 8) ? head : ~lastSdi;

  initial begin
    sck = 1'b1;
    slaveSelectN = 1'b1;
  end

  // ==========================================================
  // capture on the selected edge, shift on the other
  always @(posedge clock) begin
    prevSck <= sckLine;
    if (cnt < 8) begin
      lastSdi <= head;
    end
    if ((capRise ? rise : fall) && cnt < 8) begin
      rx <= msbFirst ? {rx[6:0], sdoLine} : {sdoLine, rx[7:1]};
      cnt <= cnt + 1;
    end else if ((capRise ? fall : rise) && cnt > 0 && cnt < 8) begin
      tx <= msbFirst ? {tx[6:0], 1'b0} : {1'b0, tx[7:1]};
    end
  end

  task automatic load(input logic [7:0] b);
    tx = b;
    cnt = 0;
  endtask

  // clock stands at its idle level outside frames
  task automatic run_master(input logic [7:0] b, input int nb);
    load(b);
    @(posedge clock);
    slaveSelectN <= 1'b0;
    repeat (8) @(posedge clock);
    repeat (nb) begin
      sck <= pol;
      repeat (8) @(posedge clock);
      sck <= ~pol;
      repeat (8) @(posedge clock);
    end
    slaveSelectN <= 1'b1;
  endtask
endmodule

// ===== verif/tb_spi_master_slave_port.sv
`timescale 1ns/1ps
module tb_spi_master_slave_port;
  import spi_port_pkg::*;
  // ==========================================================
  // stimulus and wiring
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic timerMatch = 1'b0;
  logic subClk = 1'b0;
  logic irqRequest;
  logic pol = 1'b0;
  logic edgeSel = 1'b0;
  logic msbFirst = 1'b0;
  logic sdi;
  logic sckFar;
  logic ssnFar;
  spiPinIn_t pinIn;
  spiPinOut_t pinOut;
  int failures = 0;
  int nChecks = 0;
  int cyc = 0;
  wire sckWire = pinOut.sckOe ? pinOut.sckOut : sckFar;
  wire sdoWire = pinOut.sdoOe ? pinOut.sdoOut : 1'b1;
  assign pinIn = '{subClock: subClk, slaveSelectN: ssnFar, sdi: sdi,
                   sck: sckWire};

  always #2.5 clock = ~clock;

  spi_master_slave_port uut (
    .clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .pinIn(pinIn),
    .pinOut(pinOut), .timerMatch(timerMatch), .irqRequest(irqRequest)
  );

  spi_far_end farEnd (
    .clock(clock), .pol(pol), .edgeSel(edgeSel), .msbFirst(msbFirst),
    .sckLine(sckWire), .sdoLine(sdoWire), .sdi(sdi), .sck(sckFar),
    .slaveSelectN(ssnFar)
  );

  // ==========================================================
  // clock sources for the slow modes, and the hang limit
  always @(posedge clock) begin
    cyc <= cyc + 1;
    timerMatch <= (cyc % 6 == 5);
    if (cyc % 5 == 0) begin
      subClk <= ~subClk;
    end
    if (cyc == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  // ==========================================================
  // bus tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic access(input logic wr, input logic [3:0] a,
                        input logic [7:0] d, output logic [31:0] q);
    @(posedge clock);
    address <= a;
    writedata <= {24'h00_0000, d};
    write <= wr;
    read <= ~wr;
    @(posedge clock);
    while (waitrequest !== 1'b0) @(posedge clock);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask

  task automatic rdChk(input string what, input logic [3:0] a,
                       input logic [7:0] e);
    logic [31:0] q;
    access(1'b0, a, 8'h00, q);
    check(what, q, {24'h00_0000, e});
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial begin
    logic [7:0] cfg;
    logic [7:0] tx;
    logic [7:0] rb;
    logic ok;
    int m;
    int t0;
    int half;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rdChk("ctrl0 reset", CTRL0_OFFSET, CTRL0_RESET);
    rdChk("status reset", STATUS_OFFSET, STATUS_RESET);
    rdChk("data reset", DATA_OFFSET, DATA_RESET);
    check("oe disabled", 32'({pinOut.sckOe, pinOut.sdoOe}), 32'h0);
    wr(4'hC, 8'hFF);
    rdChk("unmapped", 4'hC, 8'h00);
    wr(STATUS_OFFSET, 8'hC0);
    rdChk("spare bits", STATUS_OFFSET, 8'hC0);
    byteenable <= 4'hE;
    wr(STATUS_OFFSET, 8'h3C);
    byteenable <= 4'hF;
    rdChk("lane off", STATUS_OFFSET, 8'hC0);
    // master transfers over every mode and every clock setting
    for (int i = 0; i < 5; i++) begin
      m = (i + 1) % 5;
      pol <= i[0];
      edgeSel <= i[1];
      msbFirst <= i[0] ^ i[1] ^ i[2];
      cfg = {2'b00, i[0], i[1], i[0] ^ i[1] ^ i[2], 3'b000};
      tx = 8'h96 ^ 8'(i);
      rb = 8'h4D + 8'(i);
      wr(STATUS_OFFSET, cfg);
      wr(CTRL0_OFFSET, {3'(m), 5'h02});
      repeat (3) @(posedge clock);
      check("idle pins", 32'(pinOut), {28'h000_0000, ~pol, 3'b111});
      farEnd.load(rb);
      wr(DATA_OFFSET, tx);
      t0 = cyc;
      wr(DATA_OFFSET, ~tx);
      rdChk("data mid transfer", DATA_OFFSET, tx);
      while (irqRequest !== 1'b1) @(negedge clock);
      half = 2 << (2 * m);
      ok = (cyc - t0 >= 16 * half) && (cyc - t0 <= 16 * half + 5);
      if (m < 3) check("transfer time", {31'h0, ok}, 32'h0000_0001);
      // far end takes the last bit at most one cycle after the flag rises
      repeat (3) @(posedge clock);
      check("far end rx", 32'(farEnd.rx), 32'(tx));
      rdChk("collision done", STATUS_OFFSET, cfg | 8'h03);
      if (m != 0) begin
        rdChk("received word", DATA_OFFSET, rb);
      end
      wr(STATUS_OFFSET, cfg);
      rdChk("flags cleared", STATUS_OFFSET, cfg);
      check("irq cleared", 32'(irqRequest), 32'h0);
      wr(STATUS_OFFSET, cfg | 8'h03);
      rdChk("flags not set", STATUS_OFFSET, cfg);
    end
    // slave transfers, whole word then an early release
    pol <= 1'b0;
    edgeSel <= 1'b0;
    msbFirst <= 1'b1;
    wr(STATUS_OFFSET, 8'h0C);
    wr(CTRL0_OFFSET, {MODE_SLAVE, 5'h02});
    wr(DATA_OFFSET, 8'h5A);
    repeat (3) @(posedge clock);
    check("deselected", 32'({pinOut.sckOe, pinOut.sdoOe}), 32'h0);
    farEnd.run_master(8'hC3, 8);
    while (irqRequest !== 1'b1) @(negedge clock);
    check("slave sent", 32'(farEnd.rx), 32'h0000_005A);
    rdChk("slave received", DATA_OFFSET, 8'hC3);
    wr(STATUS_OFFSET, 8'h0C);
    wr(DATA_OFFSET, 8'h33);
    farEnd.run_master(8'hF0, 3);
    repeat (8) @(posedge clock);
    rdChk("incomplete", CTRL0_OFFSET, {MODE_SLAVE, 5'h03});
    rdChk("complete early", STATUS_OFFSET, 8'h0D);
    wr(CTRL0_OFFSET, {MODE_SLAVE, 5'h00});
    repeat (3) @(posedge clock);
    check("released", 32'({pinOut.sckOe, pinOut.sdoOe}), 32'h0);
    wr(CTRL0_OFFSET, {MODE_SLAVE, 5'h02});
    rdChk("settings kept", STATUS_OFFSET, 8'h0D);
    report_and_stop();
  end
endmodule
